// ### pkg/flash_pin_pkg.sv
package flash_pin_pkg;

    // ************************************************************
    // Command opcodes that the pin logic must recognise.
    // ************************************************************
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_READ_FAST = 8'h0B;
    localparam logic [7:0] OP_READ_DUAL = 8'h3B;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_ERASE_PAGE = 8'h81;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K_A = 8'h52;
    localparam logic [7:0] OP_ERASE_32K_B = 8'hD8;
    localparam logic [7:0] OP_ERASE_CHIP_A = 8'h60;
    localparam logic [7:0] OP_ERASE_CHIP_B = 8'hC7;
    localparam logic [7:0] OP_ERASE_CHIP_C = 8'h62;

    // ************************************************************
    // Frame layout: index of the first data byte in a frame.
    // ************************************************************
    localparam logic [2:0] DATA_IDX_SLOW = 3'h4;
    localparam logic [2:0] DATA_IDX_FAST = 3'h5;
    localparam logic [2:0] BYTE_IDX_MAX = 3'h7;
    localparam logic [1:0] ADDR_LAST = 2'h2;

    // ************************************************************
    // Array organisation: alignment masks of each erase size.
    // ************************************************************
    localparam int ADDR_W = 16;
    localparam logic [15:0] MASK_PAGE = 16'hFF00;
    localparam logic [15:0] MASK_4K = 16'hF000;
    localparam logic [15:0] MASK_32K = 16'h8000;
    localparam logic [15:0] MASK_CHIP = 16'h0000;

    // ************************************************************
    // Values after reset and fill values.
    // ************************************************************
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [2:0] RST_CNT3 = 3'h0;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 8;

    typedef enum logic [1:0] {
        ERASE_PAGE = 2'h0,
        ERASE_4K = 2'h1,
        ERASE_32K = 2'h2,
        ERASE_CHIP = 2'h3
    } erase_kind_t;

    typedef enum logic [3:0] {
        ST_OPCODE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_IGNORE = 4'b1000
    } parse_state_t;

endpackage

// ### src/flash_pin_core.sv
`timescale 1ns/10ps

// ****************************************************************
// Receive FIFO: single clock, registered occupancy count.
// ****************************************************************
module flash_pin_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    output logic [WIDTH-1:0] o_data,
    output logic o_valid,
    input wire logic i_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // Storage array.
    logic [PW-1:0] wr_ptr_r;          // Next slot to write.
    logic [PW-1:0] rd_ptr_r;          // Next slot to read.
    logic [PW:0] cnt_r;               // Words held.
    wire push = i_valid & o_ready;
    wire pop = o_valid & i_ready;

    // Full and empty come straight from the count, so they never lie.
    assign o_ready = (cnt_r != (PW+1)'(DEPTH));
    assign o_valid = (cnt_r != '0);
    assign o_data = mem[rd_ptr_r];

    // Storage has no reset; only written slots are ever read.
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr_r] <= i_data;
        end
    end

    // Pointers wrap naturally because the depth is a power of two.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_ptr_r <= push ? wr_ptr_r + 1'b1 : wr_ptr_r;
            rd_ptr_r <= pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module flash_pin_core #(
    parameter int FIFO_W = flash_pin_pkg::FIFO_WIDTH,
    parameter int FIFO_D = flash_pin_pkg::FIFO_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_dual_line_bit0,
    output logic o_dual_line_bit0,
    output logic o_dual_line_bit0_oe,
    output logic o_dual_line_bit1,
    output logic o_dual_line_bit1_oe,
    input wire logic i_wp_n,
    input wire logic i_hold_n,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic [FIFO_W-1:0] o_rx_data,
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    output logic o_rx_room,
    output logic o_rx_overflow,
    input wire logic i_array_busy,
    output logic o_erase_start,
    output flash_pin_pkg::erase_kind_t o_erase_kind,
    output logic [flash_pin_pkg::ADDR_W-1:0] o_erase_base,
    output logic o_program_start,
    output logic [flash_pin_pkg::ADDR_W-1:0] o_program_addr,
    output logic o_hw_lock,
    output logic o_standby,
    output logic o_selected
);
    import flash_pin_pkg::*;

    // ************************************************************
    // Link side: runs on the host serial clock.
    // ************************************************************

    // Deselect clears the frame state at once, even with the clock stopped.
    wire link_clr = i_cs_n | ~i_rstn;
    // Hold is only moved while the clock is low, so it is stable at edges.
    wire hold_act = ~i_hold_n;
    // Output enables also drop the moment hold is asserted.
    wire oe_clr = link_clr | hold_act;

    logic [2:0] bit_cnt_r;      // Input bit position in the byte.
    logic [6:0] shift_in_r;     // Bits of the byte being received.
    logic [7:0] rx_byte_r;      // Last whole received byte.
    logic [2:0] byte_cnt_r;     // Bytes seen in this frame, saturating.
    logic [7:0] opcode_r;       // First byte of the frame.
    logic rx_tgl_r;             // Flips once per delivered byte.
    logic [7:0] out_shift_r;    // Bits still to be driven.
    logic [2:0] out_cnt_r;      // Drive steps left in the current byte.
    logic so_r;                 // Serial output level.
    logic io0_r;                // Low dual line level.
    logic so_oe_r;              // Serial output enable.
    logic io0_oe_r;             // Low dual line enable.
    logic tx_s1_r;              // Offer toggle, first stage.
    logic tx_s2_r;              // Offer toggle, second stage.
    logic ack_tgl_r;            // Flips once per byte taken for output.
    logic [7:0] tx_buf_r;       // Byte offered to the link by the core side.
    logic tx_tgl_r;             // Flips when a new byte is offered.

    // Frame decode on the link side.
    wire [7:0] rx_full = {shift_in_r, i_dual_line_bit0};
    wire is_dual = (opcode_r == OP_READ_DUAL);
    wire is_slow = (opcode_r == OP_READ_SLOW);
    wire is_read = is_slow | is_dual | (opcode_r == OP_READ_FAST);
    wire [2:0] data_idx = is_slow ? DATA_IDX_SLOW : DATA_IDX_FAST;
    wire out_phase = is_read & (byte_cnt_r >= data_idx);
    wire byte_end = (bit_cnt_r == 3'h7);
    wire tx_have = tx_s2_r ^ ack_tgl_r;
    wire out_load = ~hold_act & out_phase & (out_cnt_r == RST_CNT3);
    wire [7:0] out_byte = out_load ? (tx_have ? tx_buf_r : IDLE_BYTE) : out_shift_r;
    wire [2:0] out_steps = is_dual ? 3'h3 : 3'h7;

    // Input shifter: bits latch on the rise, and a held rise does nothing.
    always_ff @(posedge i_sck or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt_r <= RST_CNT3;
            shift_in_r <= '0;
            rx_byte_r <= RST_BYTE;
            byte_cnt_r <= RST_CNT3;
            opcode_r <= RST_BYTE;
        end else if (!hold_act) begin
            shift_in_r <= rx_full[6:0];
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (byte_end) begin
                rx_byte_r <= rx_full;
                opcode_r <= (byte_cnt_r == RST_CNT3) ? rx_full : opcode_r;
                byte_cnt_r <= (byte_cnt_r == BYTE_IDX_MAX) ? byte_cnt_r : byte_cnt_r + 3'h1;
            end
        end
    end

    // Byte toggle lives outside the frame reset so deselect never fakes a byte.
    always_ff @(posedge i_sck or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_tgl_r <= 1'b0;
        end else if (!hold_act && !i_cs_n && byte_end && !out_phase) begin
            rx_tgl_r <= ~rx_tgl_r;
        end
    end

    // Output shifter: levels move only on the fall, one or two bits at a time.
    always_ff @(negedge i_sck or posedge link_clr) begin
        if (link_clr) begin
            out_shift_r <= IDLE_BYTE;
            out_cnt_r <= RST_CNT3;
            so_r <= 1'b0;
            io0_r <= 1'b0;
        end else if (!hold_act && out_phase) begin
            so_r <= out_byte[7];
            io0_r <= out_byte[6];
            out_shift_r <= is_dual ? {out_byte[5:0], 2'b11} : {out_byte[6:0], 1'b1};
            out_cnt_r <= out_load ? out_steps : out_cnt_r - 3'h1;
        end
    end

    // Enables return at the first fall after hold ends; the bit position is kept.
    always_ff @(negedge i_sck or posedge oe_clr) begin
        if (oe_clr) begin
            so_oe_r <= 1'b0;
            io0_oe_r <= 1'b0;
        end else begin
            so_oe_r <= out_phase;
            io0_oe_r <= out_phase & is_dual;
        end
    end

    // Offer toggle from the core passes two flops before it is compared.
    always_ff @(negedge i_sck or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_s1_r <= 1'b0;
            tx_s2_r <= 1'b0;
            ack_tgl_r <= 1'b0;
        end else begin
            tx_s1_r <= tx_tgl_r;
            tx_s2_r <= tx_s1_r;
            ack_tgl_r <= (out_load & tx_have) ? ~ack_tgl_r : ack_tgl_r;
        end
    end

    assign o_dual_line_bit1 = so_r;
    assign o_dual_line_bit1_oe = so_oe_r;
    assign o_dual_line_bit0 = io0_r;
    assign o_dual_line_bit0_oe = io0_oe_r;

    // ************************************************************
    // Core side: crossings from the link and pins.
    // ************************************************************
    logic cs_s1_r;              // Chip select, first stage.
    logic cs_s2_r;              // Chip select, second stage.
    logic cs_prev_r;            // Chip select one cycle later.
    logic rx_s1_r;              // Byte toggle, first stage.
    logic rx_s2_r;              // Byte toggle, second stage.
    logic rx_prev_r;            // Byte toggle one cycle later.
    logic ack_s1_r;             // Output acknowledge, first stage.
    logic ack_s2_r;             // Output acknowledge, second stage.
    logic wp_s1_r;              // Write protect, first stage.
    logic wp_s2_r;              // Write protect, second stage.

    // Pin levels reset to their pulled-up idle values.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_prev_r <= 1'b1;
            wp_s1_r <= 1'b1;
            wp_s2_r <= 1'b1;
            rx_s1_r <= 1'b0;
            rx_s2_r <= 1'b0;
            rx_prev_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            cs_s1_r <= i_cs_n;
            cs_s2_r <= cs_s1_r;
            cs_prev_r <= cs_s2_r;
            wp_s1_r <= i_wp_n;
            wp_s2_r <= wp_s1_r;
            rx_s1_r <= rx_tgl_r;
            rx_s2_r <= rx_s1_r;
            rx_prev_r <= rx_s2_r;
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    wire rx_new = rx_s2_r ^ rx_prev_r;
    wire frame_start = cs_prev_r & ~cs_s2_r;

    // ************************************************************
    // Core side: command parsing and array requests.
    // ************************************************************
    parse_state_t state_r;      // Where the frame's next byte belongs.
    parse_state_t state_nxt;
    logic [7:0] cmd_r;          // Opcode of the current frame.
    logic [7:0] addr_hi_r;      // Middle address byte, upper bits ignored.
    logic [1:0] addr_cnt_r;     // Address bytes taken.

    // Address is complete once the third address byte arrives.
    wire [15:0] addr_full = {addr_hi_r, rx_byte_r};
    wire addr_done = rx_new & (state_r == ST_ADDR) & (addr_cnt_r == ADDR_LAST);
    wire op_erase_page = (cmd_r == OP_ERASE_PAGE);
    wire op_erase_4k = (cmd_r == OP_ERASE_4K);
    wire op_erase_32k = (cmd_r == OP_ERASE_32K_A) | (cmd_r == OP_ERASE_32K_B);
    wire op_addr_erase = op_erase_page | op_erase_4k | op_erase_32k;
    wire new_chip = (rx_byte_r == OP_ERASE_CHIP_A) | (rx_byte_r == OP_ERASE_CHIP_B)
        | (rx_byte_r == OP_ERASE_CHIP_C);
    wire new_addr_cmd = (rx_byte_r == OP_PROGRAM) | (rx_byte_r == OP_ERASE_PAGE)
        | (rx_byte_r == OP_ERASE_4K) | (rx_byte_r == OP_ERASE_32K_A)
        | (rx_byte_r == OP_ERASE_32K_B);
    wire chip_fire = rx_new & (state_r == ST_OPCODE) & new_chip;
    wire erase_fire = (addr_done & op_addr_erase) | chip_fire;
    wire prog_fire = addr_done & (cmd_r == OP_PROGRAM);
    wire [1:0] kind_sel = op_erase_4k ? ERASE_4K : op_erase_32k ? ERASE_32K : ERASE_PAGE;
    wire [15:0] mask_sel = op_erase_4k ? MASK_4K : op_erase_32k ? MASK_32K : MASK_PAGE;

    // Next parse state; an unknown opcode ignores the rest of the frame.
    always_comb begin
        state_nxt = state_r;
        if (frame_start) begin
            state_nxt = ST_OPCODE;
        end else if (rx_new) begin
            case (state_r)
                ST_OPCODE: begin
                    state_nxt = new_addr_cmd ? ST_ADDR : ST_IGNORE;
                end
                ST_ADDR: begin
                    if (addr_cnt_r == ADDR_LAST) begin
                        state_nxt = (cmd_r == OP_PROGRAM) ? ST_DATA : ST_IGNORE;
                    end
                end
                ST_DATA: begin
                    state_nxt = ST_DATA;
                end
                default: begin
                    state_nxt = ST_IGNORE;
                end
            endcase
        end
    end

    // Parser registers; array requests are independent of hold.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= ST_IGNORE;
            cmd_r <= RST_BYTE;
            addr_hi_r <= RST_BYTE;
            addr_cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cmd_r <= (rx_new && state_r == ST_OPCODE) ? rx_byte_r : cmd_r;
            addr_hi_r <= (rx_new && state_r == ST_ADDR) ? rx_byte_r : addr_hi_r;
            addr_cnt_r <= frame_start ? 2'h0
                : (rx_new && state_r == ST_ADDR) ? addr_cnt_r + 2'h1 : addr_cnt_r;
        end
    end

    // Request outputs: the base address is the aligned start of the region.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_erase_start <= 1'b0;
            o_erase_kind <= ERASE_PAGE;
            o_erase_base <= RST_ADDR;
            o_program_start <= 1'b0;
            o_program_addr <= RST_ADDR;
        end else begin
            o_erase_start <= erase_fire;
            o_program_start <= prog_fire;
            if (chip_fire) begin
                o_erase_kind <= ERASE_CHIP;
                o_erase_base <= MASK_CHIP;
            end else if (erase_fire) begin
                o_erase_kind <= erase_kind_t'(kind_sel);
                o_erase_base <= addr_full & mask_sel;
            end
            o_program_addr <= prog_fire ? addr_full : o_program_addr;
        end
    end

    // ************************************************************
    // Core side: data paths to and from the user.
    // ************************************************************
    wire tx_accept = i_tx_valid & o_tx_ready;
    wire push_valid = rx_new & (state_r == ST_DATA);
    logic fifo_in_ready;

    // The offered byte stays frozen until the link acknowledges it.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_buf_r <= IDLE_BYTE;
            tx_tgl_r <= 1'b0;
            o_tx_ready <= 1'b0;
        end else begin
            tx_buf_r <= tx_accept ? i_tx_data : tx_buf_r;
            tx_tgl_r <= tx_accept ? ~tx_tgl_r : tx_tgl_r;
            o_tx_ready <= ~tx_accept & (tx_tgl_r == ack_s2_r);
        end
    end

    // The host cannot be stalled, so a full FIFO loses the byte and flags it.
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_overflow <= 1'b0;
            o_rx_room <= 1'b1;
            o_hw_lock <= 1'b0;
            o_standby <= 1'b1;
            o_selected <= 1'b0;
        end else begin
            o_rx_overflow <= (push_valid & ~fifo_in_ready) | (o_rx_overflow & ~frame_start);
            o_rx_room <= fifo_in_ready;
            o_hw_lock <= ~wp_s2_r;
            o_standby <= cs_s2_r & ~i_array_busy;
            o_selected <= ~cs_s2_r;
        end
    end

    flash_pin_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_rx_fifo (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_data(rx_byte_r),
        .i_valid(push_valid),
        .o_ready(fifo_in_ready),
        .o_data(o_rx_data),
        .o_valid(o_rx_valid),
        .i_ready(i_rx_ready)
    );
endmodule

// ### verification/flash_pin_properties.sv
`timescale 1ns/10ps
// ************************************************************
// Port checks of the flash pin logic, all on the core clock.
// ************************************************************
module flash_pin_props (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_cs_n,
    input wire logic i_hold_n,
    input wire logic i_wp_n,
    input wire logic i_array_busy,
    input wire logic o_dual_line_bit0_oe,
    input wire logic o_dual_line_bit1_oe,
    input wire logic o_hw_lock,
    input wire logic o_standby,
    input wire logic o_selected,
    input wire logic o_erase_start,
    input wire logic o_program_start,
    input wire flash_pin_pkg::erase_kind_t o_erase_kind,
    input wire logic [15:0] o_erase_base
);
    import flash_pin_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    // Both data lines must float the moment the host lets go of select.
    a_deselect_float: assert property (i_cs_n |-> !o_dual_line_bit0_oe && !o_dual_line_bit1_oe)
        else $error("data line driven while deselected");
    a_hold_float: assert property (!i_hold_n |-> !o_dual_line_bit0_oe && !o_dual_line_bit1_oe)
        else $error("data line driven during pause");
    // The lock input passes two sync stages and an output register, so the check waits for five steady samples.
    a_lock_applied: assert property ((i_rstn && !i_wp_n) [*5] |-> o_hw_lock)
        else $error("lock missing with protect low");
    a_lock_released: assert property ((i_rstn && i_wp_n) [*5] |-> !o_hw_lock)
        else $error("lock present with protect high");
    a_busy_standby: assert property (i_array_busy |=> !o_standby)
        else $error("standby entered while array busy");
    a_stay_selected: assert property ((i_rstn && !i_cs_n) [*5] |-> o_selected && !o_standby)
        else $error("device not selected with select low");
    a_base_4k: assert property (o_erase_start && o_erase_kind == ERASE_4K |->
        o_erase_base[11:0] == 12'h000) else $error("small block base misaligned");
    a_base_32k: assert property (o_erase_start && o_erase_kind == ERASE_32K |->
        o_erase_base[14:0] == 15'h0000) else $error("large block base misaligned");
    a_base_chip: assert property (o_erase_start && o_erase_kind == ERASE_CHIP |->
        o_erase_base == 16'h0000) else $error("chip erase base not zero");
    a_erase_pulse: assert property (o_erase_start |=> !o_erase_start)
        else $error("erase start longer than one cycle");
endmodule

// ### verification/spi_host_model.sv
`timescale 1ns/10ps
// Host master in mode 0: the clock is parked low between bytes and frames.
module spi_host_model (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_hold_n,
    output logic o_mosi,
    output logic o_mosi_en,
    input wire logic i_io0,
    input wire logic i_io1
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_hold_n = 1'b1;
        o_mosi = 1'b0;
        o_mosi_en = 1'b1;
    end
    // The core needs a few cycles to see the select fall before the first byte ends.
    task automatic begin_frame();
        o_cs_n = 1'b0;
        #400;
    endtask
    task automatic end_frame();
        #100;
        o_cs_n = 1'b1;
        #600;
    endtask
    // One byte MSB first; in dual mode the input line is released and two bits come a rise.
    task automatic byte_io(input logic [7:0] b, input bit dual, input int hold_at,
            output logic [7:0] v);
        o_mosi_en = !dual;
        v = 8'h00;
        for (int i = 0; i < (dual ? 4 : 8); i++) begin
            if (i == hold_at) begin
                // Pause only with the clock low; the clock pulse inside must be ignored.
                #20 o_hold_n = 1'b0;
                #20 o_sck = 1'b1;
                o_mosi = ~o_mosi;
                #40 o_sck = 1'b0;
                #40 o_hold_n = 1'b1;
                #40;
            end
            o_mosi = b[7 - i];
            #40 o_sck = 1'b1;
            v = dual ? {v[5:0], i_io1, i_io0} : {v[6:0], i_io1};
            #40 o_sck = 1'b0;
        end
        // The idle gap keeps every byte longer than four core cycles.
        #320;
    endtask
endmodule

// ### verification/serial_flash_pin_hold_array_map_tb_top.sv
`timescale 1ns/10ps
module serial_flash_pin_hold_array_map_tb_top;
    import flash_pin_pkg::*;
    logic i_clock = 1'b0, i_rstn = 1'b0, i_wp_n = 1'b1, i_array_busy = 1'b0, stall = 1'b0;
    logic i_rx_ready = 1'b0, i_tx_valid = 1'b0, sck, cs_n, hold_n, mosi, mosi_en, io0, io1;
    logic o_dual_line_bit0, o_dual_line_bit0_oe, o_dual_line_bit1, o_dual_line_bit1_oe;
    logic o_tx_ready, o_rx_valid, o_rx_room, o_rx_overflow, o_erase_start, o_program_start;
    logic o_hw_lock, o_standby, o_selected;
    logic [7:0] i_tx_data = 8'h00, o_rx_data, v;
    logic [15:0] o_erase_base, o_program_addr, a, seen_base, seen_pg;
    logic [17:0] e;
    erase_kind_t o_erase_kind, seen_kind;
    logic [31:0] lfsr = 32'h000144DF; // Seed 83167.
    logic [7:0] tx_q[$], rx_q[$], sent[$];
    logic [7:0] ops[7] = '{OP_ERASE_PAGE, OP_ERASE_4K, OP_ERASE_32K_A, OP_ERASE_32K_B,
        OP_ERASE_CHIP_A, OP_ERASE_CHIP_B, OP_ERASE_CHIP_C};
    int n_errors = 0, check_count = 0, cyc = 0, n_er = 0, n_pre;
    // Released lines show the inverse of their last level.
    assign io1 = o_dual_line_bit1_oe ? o_dual_line_bit1 : ~o_dual_line_bit1;
    assign io0 = o_dual_line_bit0_oe ? o_dual_line_bit0 : (mosi_en ? mosi : ~o_dual_line_bit0);
    spi_host_model host (.o_sck(sck), .o_cs_n(cs_n), .o_hold_n(hold_n), .o_mosi(mosi),
        .o_mosi_en(mosi_en), .i_io0(io0), .i_io1(io1));
    flash_pin_core dut (.i_clock, .i_rstn, .i_sck(sck), .i_cs_n(cs_n), .i_dual_line_bit0(io0),
        .o_dual_line_bit0, .o_dual_line_bit0_oe, .o_dual_line_bit1, .o_dual_line_bit1_oe,
        .i_wp_n, .i_hold_n(hold_n), .i_tx_data, .i_tx_valid, .o_tx_ready, .o_rx_data,
        .o_rx_valid, .i_rx_ready, .o_rx_room, .o_rx_overflow, .i_array_busy, .o_erase_start,
        .o_erase_kind, .o_erase_base, .o_program_start, .o_program_addr, .o_hw_lock,
        .o_standby, .o_selected);
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h80200003 : 32'h00000000);
    endfunction
    // Expected erase kind and aligned base, worked out from the opcode.
    function automatic logic [17:0] exp_erase(input logic [7:0] op, input logic [15:0] ad);
        case (op)
            OP_ERASE_PAGE: return {2'h0, ad & 16'hFF00};
            OP_ERASE_4K: return {2'h1, ad & 16'hF000};
            OP_ERASE_32K_A, OP_ERASE_32K_B: return {2'h2, ad & 16'h8000};
            default: return {2'h3, 16'h0000};
        endcase
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    // Opcode, then a random ignored top byte and the address in a.
    task automatic cmd(input logic [7:0] op, input bit with_addr);
        host.begin_frame();
        host.byte_io(op, 1'b0, -1, v);
        if (with_addr) begin
            lfsr = nxt(lfsr);
            host.byte_io(lfsr[23:16], 1'b0, -1, v);
            host.byte_io(a[15:8], 1'b0, -1, v);
            host.byte_io(a[7:0], 1'b0, -1, v);
        end
    endtask
    always #50 i_clock = ~i_clock;
    // Core side: takes handshakes at the edge, then drives the next values 1 ns later.
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (i_tx_valid && o_tx_ready) void'(tx_q.pop_front());
        if (o_rx_valid && i_rx_ready) rx_q.push_back(o_rx_data);
        if (o_erase_start) begin
            seen_kind = o_erase_kind;
            seen_base = o_erase_base;
            n_er++;
        end
        if (o_program_start) seen_pg = o_program_addr;
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
        #1;
        i_tx_valid = tx_q.size() != 0;
        i_tx_data = tx_q.size() != 0 ? tx_q[0] : 8'h00;
        i_rx_ready = !stall && lfsr[0];
        lfsr = nxt(lfsr);
    end
    initial begin
        repeat (20) @(posedge i_clock);
        #1;
        i_rstn = 1'b1;
        tick(4);
        for (int k = 0; k < 2; k++) begin
            i_wp_n = k[0];
            tick(6);
            check("hw_lock", {15'h0, !k[0]}, {15'h0, o_hw_lock});
        end
        $display("test write_protect done");
        for (int i = 0; i < 7; i++) begin
            lfsr = nxt(lfsr);
            a = i == 0 ? 16'hFFFF : lfsr[15:0];
            e = exp_erase(ops[i], a);
            cmd(ops[i], i < 4);
            host.end_frame();
            check("erase_count", 16'(i + 1), 16'(n_er));
            check("erase_kind", {14'h0, e[17:16]}, {14'h0, seen_kind});
            check("erase_base", e[15:0], seen_base);
        end
        i_array_busy = 1'b1;
        tick(3);
        check("standby_busy", 16'h0000, {15'h0, o_standby});
        i_array_busy = 1'b0;
        tick(3);
        check("standby_idle", 16'h0001, {15'h0, o_standby});
        $display("test erase done");
        lfsr = nxt(lfsr);
        a = lfsr[15:0];
        cmd(OP_PROGRAM, 1'b1);
        for (int i = 0; i < 40; i++) begin
            lfsr = nxt(lfsr);
            sent.push_back(lfsr[7:0]);
            host.byte_io(lfsr[7:0], 1'b0, i == 1 ? 3 : -1, v);
            if (i == 4) stall = 1'b1;
        end
        tick(6);
        n_pre = rx_q.size();
        check("program_addr", a, seen_pg);
        check("rx_room_full", 16'h0000, {15'h0, o_rx_room});
        check("rx_overflow", 16'h0001, {15'h0, o_rx_overflow});
        host.end_frame();
        stall = 1'b0;
        tick(120);
        check("rx_count", 16'(n_pre + 32), 16'(rx_q.size()));
        foreach (rx_q[j]) check("rx_byte", sent[j], rx_q[j]);
        $display("test program_fill done");
        for (int m = 0; m < 3; m++) begin
            sent.delete();
            repeat (2) begin
                lfsr = nxt(lfsr);
                tx_q.push_back(lfsr[7:0]);
                sent.push_back(lfsr[7:0]);
            end
            cmd(m == 0 ? OP_READ_SLOW : (m == 1 ? OP_READ_FAST : OP_READ_DUAL), 1'b1);
            check("overflow_clear", 16'h0000, {15'h0, o_rx_overflow});
            if (m != 0) host.byte_io(8'h00, 1'b0, -1, v);
            for (int j = 0; j < 3; j++) begin
                host.byte_io(8'h00, m == 2, -1, v);
                check("read_byte", j < 2 ? sent[j] : 8'hFF, v);
            end
            host.end_frame();
        end
        $display("test read done");
        stop_test();
    end
endmodule
bind flash_pin_core flash_pin_props chk (.i_clock, .i_rstn, .i_cs_n, .i_hold_n, .i_wp_n,
    .i_array_busy, .o_dual_line_bit0_oe, .o_dual_line_bit1_oe, .o_hw_lock, .o_standby,
    .o_selected, .o_erase_start, .o_program_start, .o_erase_kind, .o_erase_base);
